// ---- sensorless_tuning_cfg_regs.sv ----
// Decided for this implementation: the AXI4-Lite slave port.
module sensorless_tuning_cfg_regs (
	input wire logic mclk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [motor_tune_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [motor_tune_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [motor_tune_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [motor_tune_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// motor side
	input wire logic pwm_edge,
	input wire logic comp_raw,
	input wire logic align_active,
	input wire logic [motor_tune_pkg::DUTY_W-1:0] duty_req,
	output logic comp_out,
	output logic blank_active,
	output logic duty_capped,
	output logic [motor_tune_pkg::DUTY_W-1:0] duty_out
);
	typedef enum logic [3:0] {
		SEL_NONE = 4'h1,
		SEL_FAULT_ONE = 4'h2,
		SEL_FAULT_TWO = 4'h4,
		SEL_TUNING_TWO = 4'h8
	} reg_sel_t;

	logic [31:0] fault_settings_word_one;
	logic [31:0] fault_settings_word_two;
	logic [31:0] algorithm_tuning_word_two;
	logic [motor_tune_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] status_word;
	logic [motor_tune_pkg::DUTY_W-1:0] align_cap;
	logic [motor_tune_pkg::DUTY_W-1:0] next_duty;
	logic next_capped;
	logic write_go;
	logic status_hit;
	reg_sel_t wr_sel;

	comp_cfg_if cif ();

	// word address match, upper bits must be clear
	function automatic logic addr_is(
		input logic [motor_tune_pkg::ADDR_W-1:0] addr,
		input logic [7:0] idx
	);
		return addr[motor_tune_pkg::ADDR_W-1:2] == {2'b00, idx};
	endfunction : addr_is

	// map a byte address onto one of the writable words
	function automatic reg_sel_t decode(input logic [motor_tune_pkg::ADDR_W-1:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		if (addr_is(addr, motor_tune_pkg::IDX_FAULT_ONE)) begin
			sel = SEL_FAULT_ONE;
		end else if (addr_is(addr, motor_tune_pkg::IDX_FAULT_TWO)) begin
			sel = SEL_FAULT_TWO;
		end else if (addr_is(addr, motor_tune_pkg::IDX_TUNING_TWO)) begin
			sel = SEL_TUNING_TWO;
		end
		return sel;
	endfunction : decode

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// alignment duty limit per code, tenths of a percent
	function automatic logic [9:0] cap_of(input logic [2:0] code);
		logic [9:0] cap;
		case (code)
			3'h0: cap = motor_tune_pkg::CAP_10;
			3'h1: cap = motor_tune_pkg::CAP_15;
			3'h2: cap = motor_tune_pkg::CAP_20;
			3'h3: cap = motor_tune_pkg::CAP_25;
			3'h4: cap = motor_tune_pkg::CAP_30;
			3'h5: cap = motor_tune_pkg::CAP_40;
			3'h6: cap = motor_tune_pkg::CAP_50;
			default: cap = motor_tune_pkg::DUTY_FULL;
		endcase
		return cap;
	endfunction : cap_of

	// fields from the tuning word steer the conditioner
	assign cif.blank_code = algorithm_tuning_word_two[motor_tune_pkg::BLANK_LSB +: 4];
	assign cif.filt_code = algorithm_tuning_word_two[motor_tune_pkg::FILT_LSB +: 3];
	assign align_cap = cap_of(algorithm_tuning_word_two[motor_tune_pkg::ALIGN_LSB +: 3]);

	comp_conditioner u_cond (
		.mclk(mclk),
		.rst_n(rst_n),
		.pwm_edge(pwm_edge),
		.comp_raw(comp_raw),
		.cfg(cif.cond)
	);

	assign comp_out = cif.comp_filt;

	// blanking state seen by software and pins one cycle late
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			blank_active <= 1'b0;
		end else begin
			blank_active <= cif.blanking;
		end
	end

	// duty limit only bites while aligning
	always_comb begin
		next_duty = duty_req;
		next_capped = 1'b0;
		if (align_active && (duty_req > align_cap)) begin
			next_duty = align_cap;
			next_capped = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			duty_out <= '0;
			duty_capped <= 1'b0;
		end else begin
			duty_out <= next_duty;
			duty_capped <= next_capped;
		end
	end

	// read-only view of the block's own state
	always_comb begin
		status_word = '0;
		status_word[motor_tune_pkg::ST_COMP_BIT] = comp_out;
		status_word[motor_tune_pkg::ST_BLANK_BIT] = blank_active;
		status_word[motor_tune_pkg::ST_CAPPED_BIT] = duty_capped;
	end

	// write address channel, held until the response is taken
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_wready <= 1'b1;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// commit once both halves are in and no response is pending
	assign write_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_sel = decode(aw_addr);
	assign status_hit = addr_is(aw_addr, motor_tune_pkg::IDX_STATUS);

	// the word registers; every bit is read-write, reserved ones too
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_settings_word_one <= motor_tune_pkg::FAULT_ONE_RESET;
			fault_settings_word_two <= motor_tune_pkg::FAULT_TWO_RESET;
			algorithm_tuning_word_two <= motor_tune_pkg::TUNING_TWO_RESET;
		end else if (write_go) begin
			case (wr_sel)
				SEL_FAULT_ONE: begin
					fault_settings_word_one <= merge(fault_settings_word_one, w_data, w_strb);
				end
				SEL_FAULT_TWO: begin
					fault_settings_word_two <= merge(fault_settings_word_two, w_data, w_strb);
				end
				SEL_TUNING_TWO: begin
					algorithm_tuning_word_two <= merge(algorithm_tuning_word_two, w_data, w_strb);
				end
				default: begin
					// unmapped or status: nothing stored
				end
			endcase
		end
	end

	// write response; status writes are harmless so they answer okay
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= motor_tune_pkg::RESP_OKAY;
		end else if (write_go) begin
			s_axi_bvalid <= 1'b1;
			if ((wr_sel != SEL_NONE) || status_hit) begin
				s_axi_bresp <= motor_tune_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= motor_tune_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read path: one read at a time, data sampled at the address edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= motor_tune_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= motor_tune_pkg::RESP_OKAY;
			case (decode(s_axi_araddr))
				SEL_FAULT_ONE: begin
					s_axi_rdata <= fault_settings_word_one;
				end
				SEL_FAULT_TWO: begin
					s_axi_rdata <= fault_settings_word_two;
				end
				SEL_TUNING_TWO: begin
					s_axi_rdata <= algorithm_tuning_word_two;
				end
				default: begin
					if (addr_is(s_axi_araddr, motor_tune_pkg::IDX_STATUS)) begin
						s_axi_rdata <= status_word;
					end else begin
						// reserved locations read zero and flag an error
						s_axi_rdata <= '0;
						s_axi_rresp <= motor_tune_pkg::RESP_SLVERR;
					end
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : sensorless_tuning_cfg_regs

// ---- motor_tune_pkg.sv ----
package motor_tune_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int DUTY_W = 10;

	// printed offsets are word indexes, byte address is four times the index
	localparam logic [7:0] IDX_FAULT_ONE = 8'h92;
	localparam logic [7:0] IDX_FAULT_TWO = 8'h94;
	localparam logic [7:0] IDX_TUNING_TWO = 8'h9c;
	localparam logic [7:0] IDX_STATUS = 8'ha0;

	// values after reset
	localparam logic [31:0] TUNING_TWO_RESET = 32'h0020_0000;
	localparam logic [31:0] FAULT_ONE_RESET = 32'h0000_0000;
	localparam logic [31:0] FAULT_TWO_RESET = 32'h0000_0000;

	// tuning word field layout
	localparam int BLANK_LSB = 27;
	localparam int BLANK_W = 4;
	localparam int FILT_LSB = 24;
	localparam int FILT_W = 3;
	localparam int ALIGN_LSB = 18;
	localparam int ALIGN_W = 3;

	// status word bit positions
	localparam int ST_COMP_BIT = 0;
	localparam int ST_BLANK_BIT = 1;
	localparam int ST_CAPPED_BIT = 2;

	// timing: codes are whole microseconds
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 11;

	// duty scale in tenths of a percent
	localparam logic [9:0] DUTY_FULL = 10'h3e8;
	localparam logic [9:0] CAP_10 = 10'h064;
	localparam logic [9:0] CAP_15 = 10'h096;
	localparam logic [9:0] CAP_20 = 10'h0c8;
	localparam logic [9:0] CAP_25 = 10'h0fa;
	localparam logic [9:0] CAP_30 = 10'h12c;
	localparam logic [9:0] CAP_40 = 10'h190;
	localparam logic [9:0] CAP_50 = 10'h1f4;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// microsecond code to clock cycles
	function automatic logic [CNT_W-1:0] us_to_cycles(input logic [3:0] us);
		return CNT_W'(us) * CNT_W'(CYC_PER_US);
	endfunction : us_to_cycles

endpackage : motor_tune_pkg

// ---- comp_cfg_if.sv ----
interface comp_cfg_if;
	logic [3:0] blank_code;
	logic [2:0] filt_code;
	logic comp_filt;
	logic blanking;

	modport ctrl (
		output blank_code,
		output filt_code,
		input comp_filt,
		input blanking
	);

	modport cond (
		input blank_code,
		input filt_code,
		output comp_filt,
		output blanking
	);
endinterface : comp_cfg_if

// ---- comp_conditioner.sv ----
module comp_conditioner (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic pwm_edge,
	input wire logic comp_raw,
	comp_cfg_if.cond cfg
);
	logic [motor_tune_pkg::CNT_W-1:0] blank_cnt;
	logic [motor_tune_pkg::CNT_W-1:0] filt_cnt;
	logic [motor_tune_pkg::CNT_W-1:0] filt_target;
	logic masked;

	// the edge cycle itself is already inside the window
	assign masked = (pwm_edge && (cfg.blank_code != 4'h0)) || (blank_cnt != '0);
	assign cfg.blanking = masked;
	assign filt_target = motor_tune_pkg::us_to_cycles({1'b0, cfg.filt_code});

	// blanking window restarts on every pwm edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			blank_cnt <= '0;
		end else if (pwm_edge) begin
			blank_cnt <= motor_tune_pkg::us_to_cycles(cfg.blank_code) - ((cfg.blank_code != 4'h0) ? 11'h001 : 11'h000);
		end else if (blank_cnt != '0) begin
			blank_cnt <= blank_cnt - 11'h001;
		end
	end

	// a new level must hold for the whole deglitch time before it passes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			filt_cnt <= '0;
			cfg.comp_filt <= 1'b0;
		end else if (masked) begin
			filt_cnt <= '0;
		end else if (comp_raw == cfg.comp_filt) begin
			filt_cnt <= '0;
		end else if (filt_cnt + 11'h001 >= filt_target) begin
			cfg.comp_filt <= comp_raw;
			filt_cnt <= '0;
		end else begin
			filt_cnt <= filt_cnt + 11'h001;
		end
	end
endmodule : comp_conditioner

// ---- tune_chk_assertions.sv ----
module tune_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic comp_raw,
	input wire logic align_active,
	input wire logic [9:0] duty_req,
	input wire logic comp_out,
	input wire logic blank_active,
	input wire logic duty_capped,
	input wire logic [9:0] duty_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain, so one default for all
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// the cap only applies while aligning
	a_duty_pass: assert property (!align_active |=> duty_out == $past(duty_req))
		else $error("duty altered outside alignment");
	a_duty_never_up: assert property (align_active |=> duty_out <= $past(duty_req))
		else $error("aligned duty above request");
	a_capped_flag: assert property (1 |=> duty_capped == (duty_out != $past(duty_req)))
		else $error("capped flag disagrees with duty");
	// a masked sample can never move the comparator output
	a_blank_holds: assert property (blank_active |-> $stable(comp_out))
		else $error("comparator moved while blanked");
	a_comp_cause: assert property ($changed(comp_out) |-> comp_out == $past(comp_raw))
		else $error("comparator moved away from raw level");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");

	// main scenarios
	c_capped: cover property (duty_capped);
	c_blank: cover property (blank_active);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : tune_chk

bind sensorless_tuning_cfg_regs tune_chk chk (.*);

// ---- tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic pwm_edge = 1'h0, comp_raw = 1'h0, align_active = 1'h0;
	logic comp_out, blank_active, duty_capped;
	logic [9:0] duty_req = 10'h0, duty_out;
	logic [9:0] cap [8] = '{10'h064, 10'h096, 10'h0c8, 10'h0fa, 10'h12c, 10'h190, 10'h1f4, 10'h3e8};
	int err_count = 0;
	int n_tests = 0;
	int c;

	always #5 mclk = ~mclk;

	sensorless_tuning_cfg_regs uut (.*);

	task stop_test;
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// all driving happens 1 ns after an edge, never on it
	task tick;
		@(posedge mclk);
		#1;
	endtask : tick

	task limit(input int i);
		if (i >= 40) begin
			err_count++;
			stop_test();
		end
	endtask : limit

	// aw and w offered together, each dropped once taken
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic ta, tw, ra, rw;
		logic [1:0] rsp;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		ta = 1'h1;
		tw = 1'h1;
		for (i = 0; i < 40 && (ta || tw); i++) begin
			ra = s_axi_awready;
			rw = s_axi_wready;
			tick();
			if (ra) s_axi_awvalid <= 1'h0;
			if (ra) ta = 1'h0;
			if (rw) s_axi_wvalid <= 1'h0;
			if (rw) tw = 1'h0;
		end
		limit(i);
		for (i = 0; i < 40 && s_axi_bvalid !== 1'h1; i++) tick();
		limit(i);
		// bready one edge late on purpose, so the slave must hold its answer
		tick();
		s_axi_bready <= 1'h1;
		// bresp only moves on edges: this is its value at the handshake edge
		rsp = s_axi_bresp;
		tick();
		s_axi_bready <= 1'h0;
		chk("bresp", 32'(er), 32'(rsp));
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		int i;
		logic ra;
		logic [31:0] dat;
		logic [1:0] rsp;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (i = 0; i < 40; i++) begin
			ra = s_axi_arready;
			tick();
			if (ra) break;
		end
		limit(i);
		s_axi_arvalid <= 1'h0;
		for (i = 0; i < 40 && s_axi_rvalid !== 1'h1; i++) tick();
		limit(i);
		// rready one edge late on purpose, so the slave must hold its data
		tick();
		s_axi_rready <= 1'h1;
		// data taken as it stands at the handshake edge
		dat = s_axi_rdata;
		rsp = s_axi_rresp;
		tick();
		s_axi_rready <= 1'h0;
		chk("rdata", e, dat);
		chk("rresp", 32'(er), 32'(rsp));
	endtask : rd

	initial begin
		repeat (3) @(posedge mclk);
		#1 rst_n <= 1'h1;
		rd(12'h270, 32'h0020_0000, 2'h0);
		rd(12'h248, 32'h0, 2'h0);
		rd(12'h250, 32'h0, 2'h0);
		wr(12'h248, 32'ha5a5_5a5a, 2'h0);
		wr(12'h250, 32'h0123_4567, 2'h0);
		rd(12'h248, 32'ha5a5_5a5a, 2'h0);
		rd(12'h250, 32'h0123_4567, 2'h0);
		// one byte lane only: the other three keep their old contents
		s_axi_wstrb <= 4'h1;
		wr(12'h248, 32'hffff_ffff, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(12'h248, 32'ha5a5_5aff, 2'h0);
		// the hole between the two fault words is not storage
		wr(12'h24c, 32'hffff_ffff, 2'h2);
		rd(12'h24c, 32'h0, 2'h2);
		// full request against every cap code
		align_active <= 1'h1;
		duty_req <= 10'h3e8;
		for (c = 0; c < 8; c++) begin
			wr(12'h270, 32'h0020_0000 | (32'(c) << 18), 2'h0);
			tick();
			chk("duty_out", 32'(cap[c]), 32'(duty_out));
			chk("duty_capped", 32'(c != 7), 32'(duty_capped));
		end
		wr(12'h270, 32'h0020_0000, 2'h0);
		rd(12'h270, 32'h0020_0000, 2'h0);
		align_active <= 1'h0;
		tick();
		tick();
		chk("duty_out", 32'h3e8, 32'(duty_out));
		// deglitch of 1 us: output flips on the hundredth sample
		wr(12'h270, 32'h0120_0000, 2'h0);
		comp_raw <= 1'h1;
		repeat (99) tick();
		chk("comp_out", 32'h0, 32'(comp_out));
		tick();
		chk("comp_out", 32'h1, 32'(comp_out));
		// blank of 1 us starting on the pwm edge sample
		wr(12'h270, 32'h0820_0000, 2'h0);
		pwm_edge <= 1'h1;
		comp_raw <= 1'h0;
		tick();
		pwm_edge <= 1'h0;
		repeat (49) tick();
		chk("blank_active", 32'h1, 32'(blank_active));
		repeat (50) tick();
		chk("comp_out", 32'h1, 32'(comp_out));
		tick();
		chk("comp_out", 32'h0, 32'(comp_out));
		// zero codes: output follows the very next sample
		wr(12'h270, 32'h0020_0000, 2'h0);
		comp_raw <= 1'h1;
		tick();
		chk("comp_out", 32'h1, 32'(comp_out));
		// status view: comparator high, no blanking, no cap; writes there store nothing
		rd(12'h280, 32'h0000_0001, 2'h0);
		wr(12'h280, 32'hffff_ffff, 2'h0);
		rd(12'h280, 32'h0000_0001, 2'h0);
		stop_test();
	end
endmodule : tb
